// ---- design/dac_cmd_pkg.sv ----
// constants, field layouts and carrier types of the dac serial command port
package dac_cmd_pkg;
   // timing of the scaling engine
   localparam int CLK_MHZ = 50;
   localparam int STAGE12_NS = 600;
   localparam int STAGE3_NS = 300;
   localparam logic [5:0] STAGE12_CYC =
      6'((STAGE12_NS * CLK_MHZ + 999) / 1000);
   localparam logic [5:0] STAGE3_CYC = 6'((STAGE3_NS * CLK_MHZ + 999) / 1000);
   // frame lengths in falling serial clock edges
   localparam logic [5:0] WORD_BITS = 6'h18;
   localparam logic [5:0] CRC_FRAME_BITS = 6'h20;
   localparam logic [5:0] BIT_CNT_MAX = 6'h3f;
   localparam logic [7:0] CRC_POLY = 8'h07;
   // operation field values
   localparam logic [1:0] OP_SPECIAL = 2'h0;
   localparam logic [1:0] OP_GAIN = 2'h1;
   localparam logic [1:0] OP_OFFSET = 2'h2;
   localparam logic [1:0] OP_INPUT = 2'h3;
   // special function codes
   localparam logic [5:0] SF_CONTROL = 6'h01;
   localparam logic [5:0] SF_READ_SEL = 6'h05;
   localparam logic [5:0] SF_AB_SEL0 = 6'h06;
   localparam logic [5:0] SF_AB_SEL1 = 6'h07;
   // register kinds for serial readback and bus view
   localparam logic [2:0] RK_INPUT_A = 3'h0;
   localparam logic [2:0] RK_INPUT_B = 3'h1;
   localparam logic [2:0] RK_GAIN = 3'h2;
   localparam logic [2:0] RK_OFFSET = 3'h3;
   localparam logic [2:0] RK_CONTROL = 3'h4;
   localparam logic [2:0] VK_SCALED_A = 3'h4;
   localparam logic [2:0] VK_SCALED_B = 3'h5;
   localparam logic [2:0] VK_DAC = 3'h6;
   localparam int RD_KIND_LSB = 8;
   // control register bit positions
   localparam int CTL_PWR_DOWN = 0;
   localparam int CTL_TEMP_SD = 1;
   localparam int CTL_BANK = 2;
   localparam int CTL_CRC_ERR = 3;
   // reset values
   localparam logic [15:0] INPUT_RST = 16'h0000;
   localparam logic [15:0] GAIN_RST = 16'hffff;
   localparam logic [15:0] OFFSET_RST = 16'h8000;
   localparam logic [18:0] OFFSET_MID = 19'h08000;
   // bus register byte offsets
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_VIEW_SEL = 4'h8;
   localparam logic [3:0] REG_VIEW_DATA = 4'hc;
   localparam int CFG_VARIANT14 = 0;
   // received command word
   typedef struct packed {
      logic [1:0] op;
      logic [5:0] target;
      logic [15:0] data;
   } cmd_word_t;
   // bus view selector
   typedef struct packed {
      logic [2:0] kind;
      logic [3:0] chan;
   } view_sel_t;
   // scaling engine states
   typedef enum logic [3:0] {
      ENG_IDLE = 4'b0001,
      ENG_ST1 = 4'b0010,
      ENG_ST2 = 4'b0100,
      ENG_ST3 = 4'b1000
   } eng_state_t;
endpackage

// ---- design/dac_serial_command_port.sv ----
// serial command port of a 16-channel dac with bus-side view registers
`timescale 1ns/10ps
module dac_serial_command_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic frameSel_n,
   input wire logic sclk,
   input wire logic serial_in,
   output logic serial_out,
   output logic serialOutOe_n,
   output logic crc_fail_n,
   output logic busy_n,
   input wire logic load_outputs_n
);
   // pin synchronisers; stage 1 feeds only stage 2
   logic fsS1_q, fsS2_q, fsS3_q;
   logic sclkS1_q, sclkS2_q, sclkS3_q;
   logic sinS1_q, sinS2_q;
   logic ldS1_q, ldS2_q, ldS3_q;
   // frame state
   logic frameActive_q; // awake between select fall and rise
   logic [5:0] bitCnt_q; // falling edges seen in the frame
   logic [31:0] shift_q; // received bits, newest in bit 0
   // control register fields
   logic pwrDown_q, tempSd_q, bank_q, crcErr_q;
   logic [15:0] abSel_q; // per-channel a/b output choice
   // readback
   logic rdArm_q;
   logic [2:0] rdKind_q;
   logic [23:0] rdWord_q;
   logic serialOut_q, serialOutOe_n_q, crcFail_n_q, busy_n_q;
   // channel storage
   logic [15:0] inputA_q [16];
   logic [15:0] inputB_q [16];
   logic [15:0] gain_q [16];
   logic [15:0] offset_q [16];
   logic [15:0] scaledA_q [16];
   logic [15:0] scaledB_q [16];
   logic [15:0] dac_q [16];
   // scaling engine
   dac_cmd_pkg::eng_state_t engState_q;
   logic [5:0] engCnt_q;
   logic [3:0] curCh_q;
   logic [15:0] pending_q;
   logic [16:0] prodA_q, prodB_q;
   // bus side
   logic waitReq_q;
   logic [31:0] readData_q;
   logic variant14_q;
   dac_cmd_pkg::view_sel_t viewSel_q;

   // msb-first crc-8, register seeded with zero
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? dac_cmd_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // channel mask from the six target bits; bit 5 is not decoded
   function automatic logic [15:0] targetMask(input logic [5:0] t);
      logic [15:0] m;
      m = 16'h0000;
      case (t[4:3])
         2'h0: begin
            if (t[2:0] == 3'h0) m = 16'hffff;
            else if (t[2:0] == 3'h1) m = 16'h00ff;
            else if (t[2:0] == 3'h2) m = 16'hff00;
         end
         2'h1: m = 16'h0001 << t[2:0];
         2'h2: m = 16'h0100 << t[2:0];
         default: m = 16'h0000; // unused codes write nothing
      endcase
      return m;
   endfunction

   // lowest pending channel first
   function automatic logic [3:0] firstSet(input logic [15:0] p);
      logic [3:0] f;
      f = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (p[i]) f = 4'(i);
      end
      return f;
   endfunction

   // offset add around mid-scale with saturation
   function automatic logic [15:0] sat16(input logic [16:0] p,
                                         input logic [15:0] c);
      logic [18:0] s;
      s = {2'h0, p} + {3'h0, c} - dac_cmd_pkg::OFFSET_MID;
      if (s[18]) return 16'h0000;
      if (s[17:16] != 2'h0) return 16'hffff;
      return s[15:0];
   endfunction

   // two-flop synchronisers plus an edge stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {fsS1_q, fsS2_q, fsS3_q} <= 3'h7;
         {sclkS1_q, sclkS2_q, sclkS3_q} <= 3'h0;
         {sinS1_q, sinS2_q} <= 2'h0;
         {ldS1_q, ldS2_q, ldS3_q} <= 3'h7;
      end else begin
         {fsS1_q, fsS2_q, fsS3_q} <= {frameSel_n, fsS1_q, fsS2_q};
         {sclkS1_q, sclkS2_q, sclkS3_q} <= {sclk, sclkS1_q, sclkS2_q};
         {sinS1_q, sinS2_q} <= {serial_in, sinS1_q};
         {ldS1_q, ldS2_q, ldS3_q} <= {load_outputs_n, ldS1_q, ldS2_q};
      end
   end

   // frame edges; sclk edges are ignored unless the port is awake
   logic fsFall, fsRise, sclkFall, ldFall;
   assign fsFall = fsS3_q & ~fsS2_q;
   assign fsRise = ~fsS3_q & fsS2_q;
   assign sclkFall = sclkS3_q & ~sclkS2_q & frameActive_q & ~fsS2_q;
   assign ldFall = ldS3_q & ~ldS2_q;

   // frame tracking and msb-first shift register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frameActive_q <= 1'b0;
         bitCnt_q <= 6'h00;
         shift_q <= 32'h0000_0000;
      end else begin
         if (fsFall) begin
            frameActive_q <= 1'b1;
            bitCnt_q <= 6'h00;
         end else if (fsRise) begin
            frameActive_q <= 1'b0;
         end else if (sclkFall) begin
            shift_q <= {shift_q[30:0], sinS2_q};
            if (bitCnt_q != dac_cmd_pkg::BIT_CNT_MAX) begin
               bitCnt_q <= bitCnt_q + 6'h01;
            end
         end
      end
   end

   // word decode at frame end; any other length than 24 or 32 is dropped
   dac_cmd_pkg::cmd_word_t cmd;
   logic isCrcFrame, crcOk, commit, crcBad, isSpecial;
   logic [15:0] writeMask, storeData, rdValue;
   assign isCrcFrame = bitCnt_q == dac_cmd_pkg::CRC_FRAME_BITS;
   assign cmd = isCrcFrame ? shift_q[31:8] : shift_q[23:0];
   assign crcOk = crc8(shift_q[31:8]) == shift_q[7:0];
   assign commit = fsRise & frameActive_q
      & ((bitCnt_q == dac_cmd_pkg::WORD_BITS) | (isCrcFrame & crcOk));
   assign crcBad = fsRise & frameActive_q & isCrcFrame & ~crcOk;
   assign isSpecial = cmd.op == dac_cmd_pkg::OP_SPECIAL;
   assign writeMask = (commit & ~isSpecial) ? targetMask(cmd.target) : 16'h0000;
   // short variant keeps two zero bits under the data
   assign storeData = variant14_q ? {cmd.data[15:2], 2'h0} : cmd.data;
   logic newRead, rdRelease;
   assign newRead = commit & isSpecial
      & (cmd.target == dac_cmd_pkg::SF_READ_SEL);
   assign rdRelease = fsRise & rdArm_q & ~newRead;

   // value picked by a readback select word
   always_comb begin
      unique case (cmd.data[dac_cmd_pkg::RD_KIND_LSB +: 3])
         dac_cmd_pkg::RK_INPUT_A: rdValue = inputA_q[cmd.data[3:0]];
         dac_cmd_pkg::RK_INPUT_B: rdValue = inputB_q[cmd.data[3:0]];
         dac_cmd_pkg::RK_GAIN: rdValue = gain_q[cmd.data[3:0]];
         dac_cmd_pkg::RK_OFFSET: rdValue = offset_q[cmd.data[3:0]];
         dac_cmd_pkg::RK_CONTROL: rdValue = {11'h000, 1'b0, crcErr_q,
                                             bank_q, tempSd_q, pwrDown_q};
         default: rdValue = 16'h0000; // unknown kinds read zero
      endcase
   end

   // channel registers; only input, offset and gain are reachable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            inputA_q[i] <= dac_cmd_pkg::INPUT_RST;
            inputB_q[i] <= dac_cmd_pkg::INPUT_RST;
            gain_q[i] <= dac_cmd_pkg::GAIN_RST;
            offset_q[i] <= dac_cmd_pkg::OFFSET_RST;
         end
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (writeMask[i]) begin
               unique case (cmd.op)
                  dac_cmd_pkg::OP_INPUT: begin
                     if (bank_q) inputB_q[i] <= storeData;
                     else inputA_q[i] <= storeData;
                  end
                  dac_cmd_pkg::OP_OFFSET: offset_q[i] <= storeData;
                  dac_cmd_pkg::OP_GAIN: gain_q[i] <= storeData;
                  default: ;
               endcase
            end
         end
      end
   end

   // control and a/b select special functions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {bank_q, tempSd_q, pwrDown_q} <= 3'h0;
         abSel_q <= 16'h0000;
      end else if (commit & isSpecial) begin
         if (cmd.target == dac_cmd_pkg::SF_CONTROL) begin
            bank_q <= cmd.data[dac_cmd_pkg::CTL_BANK];
            tempSd_q <= cmd.data[dac_cmd_pkg::CTL_TEMP_SD];
            pwrDown_q <= cmd.data[dac_cmd_pkg::CTL_PWR_DOWN];
         end
         if (cmd.target == dac_cmd_pkg::SF_AB_SEL0)
            abSel_q[7:0] <= cmd.data[7:0];
         if (cmd.target == dac_cmd_pkg::SF_AB_SEL1)
            abSel_q[15:8] <= cmd.data[7:0];
      end
   end

   // crc error flag: a new mismatch beats the clearing readback
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crcErr_q <= 1'b0;
         crcFail_n_q <= 1'b1;
      end else begin
         if (crcBad) crcErr_q <= 1'b1;
         else if (rdRelease & (rdKind_q == dac_cmd_pkg::RK_CONTROL))
            crcErr_q <= 1'b0;
         crcFail_n_q <= ~crcErr_q;
      end
   end

   // readback: driven from the select word until the next frame ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdArm_q <= 1'b0;
         rdKind_q <= 3'h0;
         rdWord_q <= 24'h000000;
         serialOut_q <= 1'b0;
         serialOutOe_n_q <= 1'b1;
      end else if (newRead) begin
         rdArm_q <= 1'b1;
         rdKind_q <= cmd.data[dac_cmd_pkg::RD_KIND_LSB +: 3];
         rdWord_q <= {8'h00, rdValue};
         serialOut_q <= 1'b0;
         serialOutOe_n_q <= 1'b0;
      end else if (rdRelease) begin
         rdArm_q <= 1'b0;
         serialOut_q <= 1'b0;
         serialOutOe_n_q <= 1'b1;
      end else if (sclkFall & rdArm_q) begin
         // next bit appears after each falling edge
         rdWord_q <= {rdWord_q[22:0], 1'b0};
         serialOut_q <= rdWord_q[22];
      end
   end

   // scaling engine, one channel at a time; the serial port never writes
   // scaled results itself, so a burst of writes only queues channels
   logic engTake;
   logic [3:0] pick;
   assign pick = firstSet(pending_q);
   assign engTake = (engState_q == dac_cmd_pkg::ENG_IDLE)
      & (pending_q != 16'h0000);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_q <= 16'h0000;
      end else begin
         // queued writes win over the engine taking the same channel
         pending_q <= (pending_q & ~(engTake ? (16'h0001 << pick) : 16'h0000))
                      | writeMask;
      end
   end

   // stage sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         engState_q <= dac_cmd_pkg::ENG_IDLE;
         engCnt_q <= 6'h00;
         curCh_q <= 4'h0;
         prodA_q <= 17'h00000;
         prodB_q <= 17'h00000;
      end else begin
         unique case (engState_q)
            dac_cmd_pkg::ENG_IDLE: begin
               if (engTake) begin
                  engState_q <= dac_cmd_pkg::ENG_ST1;
                  engCnt_q <= dac_cmd_pkg::STAGE12_CYC - 6'h01;
                  curCh_q <= pick;
               end
            end
            dac_cmd_pkg::ENG_ST1: begin
               if (engCnt_q == 6'h00) begin
                  engState_q <= dac_cmd_pkg::ENG_ST2;
                  engCnt_q <= dac_cmd_pkg::STAGE12_CYC - 6'h01;
                  prodA_q <= 17'((33'(inputA_q[curCh_q])
                     * 33'({1'b0, gain_q[curCh_q]} + 17'h00001)) >> 16);
                  prodB_q <= 17'((33'(inputB_q[curCh_q])
                     * 33'({1'b0, gain_q[curCh_q]} + 17'h00001)) >> 16);
               end else engCnt_q <= engCnt_q - 6'h01;
            end
            dac_cmd_pkg::ENG_ST2: begin
               if (engCnt_q == 6'h00) begin
                  engState_q <= dac_cmd_pkg::ENG_ST3;
                  engCnt_q <= dac_cmd_pkg::STAGE3_CYC - 6'h01;
               end else engCnt_q <= engCnt_q - 6'h01;
            end
            dac_cmd_pkg::ENG_ST3: begin
               if (engCnt_q == 6'h00) engState_q <= dac_cmd_pkg::ENG_IDLE;
               else engCnt_q <= engCnt_q - 6'h01;
            end
         endcase
      end
   end

   // scaled results, then output registers only on the load strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            scaledA_q[i] <= 16'h0000;
            scaledB_q[i] <= 16'h0000;
            dac_q[i] <= 16'h0000;
         end
         busy_n_q <= 1'b1;
      end else begin
         if ((engState_q == dac_cmd_pkg::ENG_ST3) & (engCnt_q == 6'h00)) begin
            scaledA_q[curCh_q] <= sat16(prodA_q, offset_q[curCh_q]);
            scaledB_q[curCh_q] <= sat16(prodB_q, offset_q[curCh_q]);
         end
         for (int i = 0; i < 16; i++) begin
            if (ldFall)
               dac_q[i] <= abSel_q[i] ? scaledB_q[i] : scaledA_q[i];
         end
         busy_n_q <= (engState_q == dac_cmd_pkg::ENG_IDLE)
            & (pending_q == 16'h0000);
      end
   end

   // bus view of the selected storage
   logic [15:0] viewData;
   always_comb begin
      unique case (viewSel_q.kind)
         dac_cmd_pkg::RK_INPUT_A: viewData = inputA_q[viewSel_q.chan];
         dac_cmd_pkg::RK_INPUT_B: viewData = inputB_q[viewSel_q.chan];
         dac_cmd_pkg::RK_GAIN: viewData = gain_q[viewSel_q.chan];
         dac_cmd_pkg::RK_OFFSET: viewData = offset_q[viewSel_q.chan];
         dac_cmd_pkg::VK_SCALED_A: viewData = scaledA_q[viewSel_q.chan];
         dac_cmd_pkg::VK_SCALED_B: viewData = scaledB_q[viewSel_q.chan];
         dac_cmd_pkg::VK_DAC: viewData = dac_q[viewSel_q.chan];
         default: viewData = 16'h0000;
      endcase
   end

   // avalon slave: one wait cycle, write lands at the completing edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitReq_q <= 1'b1;
         readData_q <= 32'h0000_0000;
         variant14_q <= 1'b0;
         viewSel_q <= '0;
      end else if ((avs_read | avs_write) & waitReq_q) begin
         waitReq_q <= 1'b0;
         unique case (avs_address)
            dac_cmd_pkg::REG_CONFIG: readData_q <= {31'h0, variant14_q};
            dac_cmd_pkg::REG_STATUS: readData_q <= {28'h0, rdArm_q,
               frameActive_q, ~busy_n_q, crcErr_q};
            dac_cmd_pkg::REG_VIEW_SEL: readData_q <= {25'h0, viewSel_q};
            dac_cmd_pkg::REG_VIEW_DATA: readData_q <= {16'h0, viewData};
            default: readData_q <= 32'h0000_0000; // unmapped reads zero
         endcase
      end else begin
         waitReq_q <= 1'b1;
         if (avs_write & ~waitReq_q & avs_byteenable[0]) begin
            if (avs_address == dac_cmd_pkg::REG_CONFIG)
               variant14_q <= avs_writedata[dac_cmd_pkg::CFG_VARIANT14];
            if (avs_address == dac_cmd_pkg::REG_VIEW_SEL)
               viewSel_q <= avs_writedata[6:0];
         end
      end
   end

   assign avs_readdata = readData_q;
   assign avs_waitrequest = waitReq_q;
   assign serial_out = serialOut_q;
   assign serialOutOe_n = serialOutOe_n_q;
   assign crc_fail_n = crcFail_n_q;
   assign busy_n = busy_n_q;

   // checks
   logic inSt1, inSt3;
   assign inSt1 = engState_q == dac_cmd_pkg::ENG_ST1;
   assign inSt3 = engState_q == dac_cmd_pkg::ENG_ST3;
   property p_shortAbort;
      @(posedge clk) disable iff (!rst_n)
      (fsRise && bitCnt_q < dac_cmd_pkg::WORD_BITS)
      |-> !commit && writeMask == 16'h0000;
   endproperty
   a_shortAbort: assert property (p_shortAbort)
      else $error("short frame wrote");
   property p_crcPin;
      @(posedge clk) disable iff (!rst_n) crcBad |-> ##2 !crc_fail_n;
   endproperty
   a_crcPin: assert property (p_crcPin)
      else $error("crc pin not low");
   // the engine may drain the queue meanwhile; only new entries are wrong
   property p_crcNoWrite;
      @(posedge clk) disable iff (!rst_n)
      crcBad |=> crcErr_q && (pending_q & ~$past(pending_q)) == 16'h0000;
   endproperty
   a_crcNoWrite: assert property (p_crcNoWrite)
      else $error("bad crc accepted");
   property p_ctlClear;
      @(posedge clk) disable iff (!rst_n)
      (rdRelease && rdKind_q == dac_cmd_pkg::RK_CONTROL && !crcBad)
      |=> !crcErr_q ##1 crc_fail_n;
   endproperty
   a_ctlClear: assert property (p_ctlClear)
      else $error("error not cleared");
   property p_oeOnRead;
      @(posedge clk) disable iff (!rst_n) newRead |=> !serialOutOe_n && rdArm_q;
   endproperty
   a_oeOnRead: assert property (p_oeOnRead)
      else $error("readback not driven");
   property p_oeIdle;
      @(posedge clk) disable iff (!rst_n) !rdArm_q |-> serialOutOe_n;
   endproperty
   a_oeIdle: assert property (p_oeIdle)
      else $error("serial out driven idle");
   property p_stage1;
      @(posedge clk) disable iff (!rst_n)
      $rose(inSt1) |-> ##29 inSt1 ##1 engState_q == dac_cmd_pkg::ENG_ST2;
   endproperty
   a_stage1: assert property (p_stage1)
      else $error("stage one length");
   property p_stage3;
      @(posedge clk) disable iff (!rst_n)
      $rose(inSt3) |-> ##14 inSt3 ##1 !inSt3;
   endproperty
   a_stage3: assert property (p_stage3)
      else $error("stage three length");
   // asleep: no edge is taken and the received bits stay put
   property p_sleep;
      @(posedge clk) disable iff (!rst_n)
      !frameActive_q |-> !sclkFall ##1 $stable(shift_q);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("clocked while idle");
   property p_bankB;
      @(posedge clk) disable iff (!rst_n)
      (commit && cmd.op == dac_cmd_pkg::OP_INPUT && bank_q
         && writeMask == 16'h0001)
      |=> inputB_q[0] == $past(storeData);
   endproperty
   a_bankB: assert property (p_bankB)
      else $error("bank b write missed");
   c_crcGood: cover property (@(posedge clk) commit && isCrcFrame);
   c_crcBad: cover property (@(posedge clk) crcBad);
   c_readback: cover property (@(posedge clk) rdRelease);
   c_groupWrite: cover property (@(posedge clk) writeMask == 16'hff00);
endmodule

// ---- verification/spi_host_model.sv ----
// host-side serial master model driving the command port
`timescale 1ns/10ps
module spi_host_model (
   input wire logic clk,
   output logic frameSel_n,
   output logic sclk,
   output logic serial_in,
   input wire logic serial_out
);
   // idle levels: select high, gated clock parked low
   initial begin
      frameSel_n = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end
   // n gated pulses, msb first; 160 ns period keeps under both caps
   task automatic frame(input int n, input logic [31:0] w,
      output logic [31:0] rd);
      rd = '0;
      @(posedge clk) frameSel_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b1;
         serial_in <= w[31-i];
         repeat (4) @(posedge clk);
         rd = {rd[30:0], serial_out};
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      frameSel_n <= 1'b1;
      // released data line shows the inverse, not the last bit
      serial_in <= ~serial_in;
      // gap also outlasts the first scaling stage
      repeat (40) @(posedge clk);
   endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the dac serial command port
`timescale 1ns/10ps
module testbench;
   logic clk, rst_n, avsRead, avsWrite, fsN, sclk, sin, sout, oeN;
   logic crcFail_n, busy_n, loadOutputs_n, avsWaitrequest;
   logic [3:0] avsAddress;
   logic [31:0] avsWritedata, avsReaddata, rd;
   int n_mismatch = 0;
   int num_checks = 0;
   int waitCnt;
   dac_serial_command_port i_dac_serial_command_port (.clk(clk),
      .rst_n(rst_n), .avs_address(avsAddress), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_byteenable(4'hf), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWaitrequest), .frameSel_n(fsN), .sclk(sclk),
      .serial_in(sin), .serial_out(sout), .serialOutOe_n(oeN),
      .crc_fail_n(crcFail_n), .busy_n(busy_n),
      .load_outputs_n(loadOutputs_n));
   // a released serial out floats up to its pull-up level
   spi_host_model i_spi_host_model (.clk(clk), .frameSel_n(fsN),
      .sclk(sclk), .serial_in(sin), .serial_out(oeN ? 1'b1 : sout));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // verdict and end of run, also reached by a spent wait
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] wd, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWritedata <= wd;
      do begin
         @(posedge clk);
         k++;
      end while (avsWaitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
      q = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   // crc-8 over the 24 command bits, msb first, seed zero
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   initial begin
      rst_n = 1'b0;
      {avsRead, avsWrite, avsAddress, avsWritedata} = '0;
      loadOutputs_n = 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      // single channel input write, then a short frame that must abort
      bus(1'b1, 4'h8, 32'h00, rd);
      i_spi_host_model.frame(24, {24'hc81234, 8'h00}, rd);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'h1234);
      i_spi_host_model.frame(20, {24'hc85555, 8'h00}, rd);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'h1234);
      $display("test 1 done");
      // all-channel offset write seen at channel 5
      bus(1'b1, 4'h8, 32'h35, rd);
      i_spi_host_model.frame(24, {24'h804321, 8'h00}, rd);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'h4321);
      $display("test 2 done");
      // gain write to channel 11, bad crc then good crc
      bus(1'b1, 4'h8, 32'h2b, rd);
      i_spi_host_model.frame(32, {24'h53abcd, crc8(24'h53abcd) ^ 8'h01}, rd);
      check({31'h0, crcFail_n}, 32'h0);
      bus(1'b0, 4'h4, 32'h0, rd);
      check(rd & 32'h1, 32'h1);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'hffff);
      i_spi_host_model.frame(32, {24'h53abcd, crc8(24'h53abcd)}, rd);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'habcd);
      $display("test 3 done");
      // control readback returns the error bit and clears it
      i_spi_host_model.frame(24, {24'h050400, 8'h00}, rd);
      check({31'h0, oeN}, 32'h0);
      i_spi_host_model.frame(24, 32'h0, rd);
      check(rd & 32'hffffff, 32'h8);
      check({31'h0, crcFail_n}, 32'h1);
      check({31'h0, oeN}, 32'h1);
      $display("test 4 done");
      // bank bit set steers channel data into input register b
      i_spi_host_model.frame(24, {24'h010004, 8'h00}, rd);
      i_spi_host_model.frame(24, {24'hc80777, 8'h00}, rd);
      bus(1'b1, 4'h8, 32'h10, rd);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'h0777);
      $display("test 5 done");
      // short variant: config reads back, data keeps its zero low bits
      bus(1'b1, 4'h0, 32'h1, rd);
      bus(1'b0, 4'h0, 32'h0, rd);
      check(rd, 32'h1);
      i_spi_host_model.frame(24, {24'hc9abcc, 8'h00}, rd);
      bus(1'b1, 4'h0, 32'h0, rd);
      bus(1'b1, 4'h8, 32'h11, rd);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'habcc);
      $display("test 6 done");
      // offset on channel 0 scales in the background; outputs wait for load
      bus(1'b1, 4'h8, 32'h60, rd);
      i_spi_host_model.frame(24, {24'h889000, 8'h00}, rd);
      check({31'h0, busy_n}, 32'h0);
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'h0);
      waitCnt = 0;
      while (busy_n !== 1'b1 && waitCnt < 2000) begin
         @(posedge clk);
         waitCnt++;
      end
      if (waitCnt >= 2000) begin
         n_mismatch++;
         report_and_stop();
      end
      @(posedge clk);
      loadOutputs_n <= 1'b0;
      repeat (4) @(posedge clk);
      loadOutputs_n <= 1'b1;
      bus(1'b0, 4'hc, 32'h0, rd);
      check(rd, 32'h2234);
      $display("test 7 done");
      report_and_stop();
   end
endmodule
